/* File: logic/gnd_oc_pkg.sv */
/*
 * Shared constants for the ground overcurrent stage: register map,
 * control field layout, curve and reset mode codes, curve tables.
 * Assumes a 10 MHz protection clock and a 1 ms timing base.
 */
package gnd_oc_pkg;

	// clocking and timing base
	localparam int CLK_HZ         = 10_000_000;
	localparam int TICK_MS        = 1;
	localparam int TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
	localparam real RX_TMIN_S     = 0.02;
	localparam int RX_TMIN_MS     = int'(RX_TMIN_S * 1000.0) / TICK_MS;

	// register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_PICKUP  = 8'h04;
	localparam logic [7:0] REG_NOMINAL = 8'h08;
	localparam logic [7:0] REG_DELAY   = 8'h0c;
	localparam logic [7:0] REG_TMS     = 8'h10;
	localparam logic [7:0] REG_RHOLD   = 8'h14;
	localparam logic [7:0] REG_UMIN    = 8'h18;
	localparam logic [7:0] REG_STATE   = 8'h1c;
	localparam logic [7:0] REG_IRQ_ST  = 8'h20;
	localparam logic [7:0] REG_IRQ_EN  = 8'h24;
	localparam logic [7:0] REG_ACC     = 8'h28;
	localparam logic [7:0] REG_CMD     = 8'h2c;

	// control register fields and reset values
	localparam int B_EN     = 0;
	localparam int B_DIR    = 1;
	localparam int B_RMS    = 2;
	localparam int B_GCALC  = 3;
	localparam int B_SENS   = 4;
	localparam int B_VCALC  = 5;
	localparam int F_RMODE  = 6;
	localparam int F_CURVE  = 8;
	localparam int B_CLEAR  = 0;
	localparam int TMS_FRAC = 8;
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [15:0] TMS_RST   = 16'h0100;
	localparam logic [15:0] LEVEL_RST = 16'hffff;

	// limiting current and tier multiples
	localparam int LIM_PICKUP_X = 20;
	localparam int LIM_CALC_X   = 40;
	localparam int LIM_MEAS_X   = 25;
	localparam int LIM_SENS_X2  = 5;
	localparam int TIER1_X      = 5;
	localparam int TIER2_X      = 10;
	localparam int TIER3_X      = 20;

	typedef enum logic [3:0] {
		definite_time_curve        = 4'h0,
		normal_inverse_curve       = 4'h1,
		very_inverse_curve         = 4'h2,
		long_inverse_curve         = 4'h3,
		extreme_inverse_curve      = 4'h4,
		moderate_inverse_curve     = 4'h5,
		ieee_very_inverse_curve    = 4'h6,
		ieee_extreme_inverse_curve = 4'h7,
		r_shaped_inverse_curve     = 4'h8,
		logarithmic_ground_curve   = 4'h9,
		flat_thermal_curve         = 4'ha,
		linear_thermal_curve       = 4'hb,
		square_thermal_curve       = 4'hc,
		fourth_power_thermal_curve = 4'hd
	} curve_t;

	typedef enum logic [1:0] {
		reset_instant  = 2'h0,
		reset_definite = 2'h1,
		reset_inverse  = 2'h2
	} reset_mode_t;

	typedef enum logic [3:0] {
		st_idle = 4'b0001,
		st_run  = 4'b0010,
		st_hold = 4'b0100,
		st_trip = 4'b1000
	} state_t;

	// per curve, ms at multiplier 1.0: {reset, x20, x10, x5, x2}
	function automatic logic [99:0] curve_row(input curve_t c);
		case (c)
		normal_inverse_curve:       return 100'h0008c_008dd_00b9c_010b9_0272e;
		very_inverse_curve:         return 100'h034bc_002c7_005dc_00d2f_034bc;
		long_inverse_curve:         return 100'h1d4c0_018ac_03415_07530_1d4c0;
		extreme_inverse_curve:      return 100'h13880_000c9_00328_00d05_0682b;
		moderate_inverse_curve:     return 100'h012f2_003b5_004b7_00699_00edb;
		ieee_very_inverse_curve:    return 100'h05460_0021c_002b1_0051c_01b74;
		ieee_extreme_inverse_curve: return 100'h071ac_000c0_00197_00511_02532;
		r_shaped_inverse_curve:     return 100'h003e8_00bf0_00c63_00d63_011ad;
		logarithmic_ground_curve:   return 100'h00000_006dc_00a84_00e2b_01300;
		flat_thermal_curve:         return 100'h01388_01388_01388_01388_01388;
		linear_thermal_curve:       return 100'h01388_000fa_001f4_003e8_009c4;
		square_thermal_curve:       return 100'h01388_0000d_00032_000c8_004e2;
		fourth_power_thermal_curve: return 100'h01388_00001_00001_00008_00138;
		default:                    return 100'h0;
		endcase
	endfunction

endpackage

/* File: logic/ground_overcurrent_stage.sv */
/*
 * Ground overcurrent stage: pickup compare, curve timing, reset modes,
 * minimum delays, clear-all, register port and interrupt.
 * Assumes magnitudes and direction flags synchronous to mclk.
 */
// Chosen here: the register addresses and the strobed register port.
// Operation
// [RULE1] non-directional mode ignores direction inputs
// [RULE2] setting picks fundamental or true RMS
// [RULE3] settings pick measured or calculated sources
// [RULE4] curve setting selects one of fourteen curves
// [RULE5] current above pickup starts trip timer
// [RULE6] definite time trips after fixed delay
// [RULE7] other curves: delay from multiplier, curve, current
// [RULE8] instantaneous reset zeroes timer within two cycles
// [RULE9] definite reset waits hold time before reset
// [RULE10] inverse reset delay from curve, not definite/log
// [RULE11] limited curves never beat two minimum delays
// [RULE12] user minimum timer gates trip, zero disables
// [RULE13] limiting current is smallest of four limits; code uses the smaller of 20x pickup and the nominal limit for the input
// [RULE14] intrinsic minimum is delay at limiting current
// [RULE15] logarithmic curve minimum fixed at 0.02 s
// [RULE16] definite time curve always resets instantly
// [RULE17] clear-all resets element and timers at once
// [RULE18] pickup while above level, trip when elapsed
// [RULE19] return above pickup resumes retained time
`timescale 1ns/1ps
module ground_overcurrent_stage #(
	parameter int TICK_CYCLES = gnd_oc_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// register port
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	// measured ground quantities
	input  wire logic [15:0] meas_fund,
	input  wire logic [15:0] meas_rms,
	input  wire logic [15:0] calc_fund,
	input  wire logic [15:0] calc_rms,
	input  wire logic        dir_fwd_meas,
	input  wire logic        dir_fwd_calc,
	// global clear and outputs
	input  wire logic        clear_all,
	output logic             pickup,
	output logic             trip,
	output logic             irq
);
	if (TICK_CYCLES < 2) begin : g_chk
		$error("tick divider needs at least two cycles");
	end

	logic [31:0] ctrl_q, definite_time_curve_q, rhold_q, umin_q, acc_q, acc_d;
	logic [31:0] hcnt_q, hcnt_d, ucnt_q, ucnt_d, rdata_q;
	logic [15:0] pickup_lvl_q, nominal_q, tms_q;
	logic [1:0]  irq_st_q, irq_en_q, irq_st_d, ev;
	logic [31:0] tick_q;
	logic        tick, pickup_q, trip_q, irq_q;
	gnd_oc_pkg::state_t st_q, st_d;

	// 1 ms timing base from the protection clock
	assign tick = (tick_q == 32'(TICK_CYCLES - 1));
	always_ff @(posedge mclk) begin
		if (rst || tick)
			tick_q <= 32'h0;
		else
			tick_q <= tick_q + 32'h1;
	end

	// quantity selection
	wire        use_rms  = ctrl_q[gnd_oc_pkg::B_RMS];
	wire        g_calc   = ctrl_q[gnd_oc_pkg::B_GCALC];
	wire        sens     = ctrl_q[gnd_oc_pkg::B_SENS] & ~g_calc;
	wire [15:0] meas_sel = use_rms ? meas_rms : meas_fund; // RULE2
	wire [15:0] calc_sel = use_rms ? calc_rms : calc_fund; // RULE2
	wire [15:0] cur      = g_calc ? calc_sel : meas_sel; // RULE3
	wire        dir_fwd  = ctrl_q[gnd_oc_pkg::B_VCALC] ?
		dir_fwd_calc : dir_fwd_meas; // RULE3
	// direction consulted only in directional mode
	wire dir_ok = ~ctrl_q[gnd_oc_pkg::B_DIR] | dir_fwd; // RULE1
	wire pu = ctrl_q[gnd_oc_pkg::B_EN] & dir_ok &
		(cur > pickup_lvl_q); // RULE5

	// curve and reset mode decode
	wire gnd_oc_pkg::curve_t curve =
		gnd_oc_pkg::curve_t'(ctrl_q[gnd_oc_pkg::F_CURVE +: 4]); // RULE4
	wire gnd_oc_pkg::reset_mode_t rmode =
		gnd_oc_pkg::reset_mode_t'(ctrl_q[gnd_oc_pkg::F_RMODE +: 2]);
	wire is_definite_time_curve  = (curve == gnd_oc_pkg::definite_time_curve);
	wire is_rx    = (curve == gnd_oc_pkg::logarithmic_ground_curve);
	wire is_therm = (curve >= gnd_oc_pkg::flat_thermal_curve);
	wire limited  = ~is_definite_time_curve & ~is_therm; // RULE11

	// limiting current, smallest of the applicable limits
	wire [21:0] pu22  = 22'(pickup_lvl_q);
	wire [21:0] nom22 = 22'(nominal_q);
	wire [21:0] lim_p = pu22 * 22'(gnd_oc_pkg::LIM_PICKUP_X); // RULE13
	wire [21:0] lim_n = g_calc ? nom22 * 22'(gnd_oc_pkg::LIM_CALC_X) :
		sens ? (nom22 * 22'(gnd_oc_pkg::LIM_SENS_X2)) >> 1 :
		nom22 * 22'(gnd_oc_pkg::LIM_MEAS_X); // RULE13
	wire [21:0] lim   = (lim_p < lim_n) ? lim_p : lim_n; // RULE13
	// clamping the current holds delay at or above its value at limit
	wire [21:0] cur_cl = (limited && 22'(cur) > lim) ? lim :
		22'(cur); // RULE14

	// multiple tier against pickup, or nominal for thermal curves
	wire [21:0] refv = is_therm ? nom22 : pu22; // RULE7
	wire [1:0] tier =
		(cur_cl >= refv * 22'(gnd_oc_pkg::TIER3_X)) ? 2'h3 :
		(cur_cl >= refv * 22'(gnd_oc_pkg::TIER2_X)) ? 2'h2 :
		(cur_cl >= refv * 22'(gnd_oc_pkg::TIER1_X)) ? 2'h1 : 2'h0;
	wire [99:0] row     = gnd_oc_pkg::curve_row(curve);
	wire [19:0] trip_ms = row[20 * tier +: 20]; // RULE7
	wire [19:0] tau_ms  = row[80 +: 20]; // RULE10
	wire [47:0] trip_p  = 48'(trip_ms) * 48'(tms_q); // RULE7
	wire [47:0] tau_p   = 48'(tau_ms) * 48'(tms_q); // RULE10
	wire [31:0] base    = trip_p[gnd_oc_pkg::TMS_FRAC +: 32];
	wire [31:0] tau_sc  = tau_p[gnd_oc_pkg::TMS_FRAC +: 32];
	wire [31:0] rx_min  = 32'(gnd_oc_pkg::RX_TMIN_MS);
	wire [31:0] eff = is_definite_time_curve ? definite_time_curve_q : // RULE6
		(is_rx && base < rx_min) ? rx_min : base; // RULE15

	// user minimum runs apart from the curve; zero switches it off
	wire umin_ok = ~limited || (umin_q == 32'h0) ||
		(ucnt_q >= umin_q); // RULE12
	wire trip_go = pu && (acc_q >= eff) && umin_ok; // RULE18

	// reset behaviour on dropout
	wire inst_drop = is_definite_time_curve || // RULE16
		(rmode == gnd_oc_pkg::reset_instant) || // RULE8
		(rmode == gnd_oc_pkg::reset_inverse && is_rx) || // RULE10
		(rmode != gnd_oc_pkg::reset_definite &&
		 rmode != gnd_oc_pkg::reset_inverse);
	wire [31:0] rlim = (rmode == gnd_oc_pkg::reset_definite) ?
		rhold_q : tau_sc; // RULE9 RULE10

	// register strobes
	wire wr_ctrl  = wr && addr == gnd_oc_pkg::REG_CTRL;
	wire wr_irq   = wr && addr == gnd_oc_pkg::REG_IRQ_ST;
	wire clr      = clear_all || (wr && addr == gnd_oc_pkg::REG_CMD &&
		wdata[gnd_oc_pkg::B_CLEAR]); // RULE17
	wire [31:0] acc_inc = (acc_q == 32'hffff_ffff) ? acc_q :
		acc_q + 32'h1;

	// timer state machine; retained time survives the hold phase
	always_comb begin
		st_d   = st_q;
		acc_d  = acc_q;
		hcnt_d = hcnt_q;
		ucnt_d = ucnt_q;
		case (st_q)
		gnd_oc_pkg::st_idle: begin
			acc_d  = 32'h0;
			ucnt_d = 32'h0;
			if (pu)
				st_d = gnd_oc_pkg::st_run; // RULE5
		end
		gnd_oc_pkg::st_run, gnd_oc_pkg::st_trip: begin
			if (!pu) begin
				ucnt_d = 32'h0;
				hcnt_d = 32'h0;
				if (inst_drop) begin
					st_d  = gnd_oc_pkg::st_idle; // RULE8
					acc_d = 32'h0;
				end else begin
					st_d = gnd_oc_pkg::st_hold; // RULE9
				end
			end else begin
				if (tick) begin
					acc_d  = acc_inc;
					ucnt_d = (ucnt_q == 32'hffff_ffff) ? ucnt_q :
						ucnt_q + 32'h1;
				end
				if (trip_go)
					st_d = gnd_oc_pkg::st_trip; // RULE18
			end
		end
		gnd_oc_pkg::st_hold: begin
			if (pu) begin
				st_d = gnd_oc_pkg::st_run; // RULE19
			end else if (hcnt_q >= rlim) begin
				st_d  = gnd_oc_pkg::st_idle; // RULE9
				acc_d = 32'h0;
			end else if (tick) begin
				hcnt_d = hcnt_q + 32'h1;
			end
		end
		default: begin
			st_d  = gnd_oc_pkg::st_idle;
			acc_d = 32'h0;
		end
		endcase
		if (clr) begin
			st_d   = gnd_oc_pkg::st_idle; // RULE17
			acc_d  = 32'h0;
			hcnt_d = 32'h0;
			ucnt_d = 32'h0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_q   <= gnd_oc_pkg::st_idle;
			acc_q  <= 32'h0;
			hcnt_q <= 32'h0;
			ucnt_q <= 32'h0;
		end else begin
			st_q   <= st_d;
			acc_q  <= acc_d;
			hcnt_q <= hcnt_d;
			ucnt_q <= ucnt_d;
		end
	end

	// outputs from flops; clear drops trip in the same edge
	always_ff @(posedge mclk) begin
		if (rst) begin
			pickup_q <= 1'b0;
			trip_q   <= 1'b0;
		end else begin
			pickup_q <= pu; // RULE18
			trip_q   <= (st_d == gnd_oc_pkg::st_trip); // RULE18
		end
	end

	// interrupt status: set wins over write-one-to-clear
	assign ev = {(st_d == gnd_oc_pkg::st_trip) & ~trip_q,
		pu & ~pickup_q};
	assign irq_st_d = (irq_st_q & ~(wr_irq ? wdata[1:0] : 2'h0)) | ev;
	always_ff @(posedge mclk) begin
		if (rst) begin
			irq_st_q <= 2'h0;
			irq_q    <= 1'b0;
		end else begin
			irq_st_q <= irq_st_d;
			irq_q    <= |(irq_st_d & irq_en_q);
		end
	end

	// setting registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_q       <= gnd_oc_pkg::CTRL_RST;
			pickup_lvl_q <= gnd_oc_pkg::LEVEL_RST;
			nominal_q    <= gnd_oc_pkg::LEVEL_RST;
			tms_q        <= gnd_oc_pkg::TMS_RST;
			definite_time_curve_q       <= 32'h0;
			rhold_q      <= 32'h0;
			umin_q       <= 32'h0;
			irq_en_q     <= 2'h0;
		end else if (wr) begin
			case (addr)
			gnd_oc_pkg::REG_CTRL:    ctrl_q <= wdata;
			gnd_oc_pkg::REG_PICKUP:  pickup_lvl_q <= wdata[15:0];
			gnd_oc_pkg::REG_NOMINAL: nominal_q <= wdata[15:0];
			gnd_oc_pkg::REG_TMS:     tms_q <= wdata[15:0];
			gnd_oc_pkg::REG_DELAY:   definite_time_curve_q <= wdata;
			gnd_oc_pkg::REG_RHOLD:   rhold_q <= wdata;
			gnd_oc_pkg::REG_UMIN:    umin_q <= wdata;
			gnd_oc_pkg::REG_IRQ_EN:  irq_en_q <= wdata[1:0];
			default: ;
			endcase
		end
	end

	// read mux; unmapped offsets read zero
	wire [31:0] rd_mux =
		(addr == gnd_oc_pkg::REG_CTRL)    ? ctrl_q :
		(addr == gnd_oc_pkg::REG_PICKUP)  ? 32'(pickup_lvl_q) :
		(addr == gnd_oc_pkg::REG_NOMINAL) ? 32'(nominal_q) :
		(addr == gnd_oc_pkg::REG_DELAY)   ? definite_time_curve_q :
		(addr == gnd_oc_pkg::REG_TMS)     ? 32'(tms_q) :
		(addr == gnd_oc_pkg::REG_RHOLD)   ? rhold_q :
		(addr == gnd_oc_pkg::REG_UMIN)    ? umin_q :
		(addr == gnd_oc_pkg::REG_STATE)   ?
			{26'h0, st_q, trip_q, pickup_q} :
		(addr == gnd_oc_pkg::REG_IRQ_ST)  ? 32'(irq_st_q) :
		(addr == gnd_oc_pkg::REG_IRQ_EN)  ? 32'(irq_en_q) :
		(addr == gnd_oc_pkg::REG_ACC)     ? acc_q : 32'h0;
	always_ff @(posedge mclk) begin
		if (rst)
			rdata_q <= 32'h0;
		else
			rdata_q <= rd ? rd_mux : 32'h0;
	end

	assign rdata  = rdata_q;
	assign pickup = pickup_q;
	assign trip   = trip_q;
	assign irq    = irq_q;

	// checks
	property p_nondir;
		@(posedge mclk) disable iff (rst)
		ctrl_q[gnd_oc_pkg::B_EN] && !ctrl_q[gnd_oc_pkg::B_DIR] &&
		cur > pickup_lvl_q |=> pickup_q;
	endproperty
	a_nondir: assert property (p_nondir) // RULE1
		else $error("non-directional pickup missed");

	property p_start;
		@(posedge mclk) disable iff (rst)
		st_q == gnd_oc_pkg::st_idle && pu && !clr
		|=> st_q == gnd_oc_pkg::st_run && acc_q == 32'h0;
	endproperty
	a_start: assert property (p_start) // RULE5
		else $error("timer did not start at pickup");

	property p_definite_time_curve;
		@(posedge mclk) disable iff (rst)
		is_definite_time_curve && st_q == gnd_oc_pkg::st_run && pu && !clr &&
		acc_q >= definite_time_curve_q |=> trip_q;
	endproperty
	a_definite_time_curve: assert property (p_definite_time_curve) // RULE6
		else $error("definite time trip late");

	property p_inst;
		@(posedge mclk) disable iff (rst)
		st_q == gnd_oc_pkg::st_run && !pu && inst_drop
		|=> st_q == gnd_oc_pkg::st_idle ##1 acc_q == 32'h0;
	endproperty
	a_inst: assert property (p_inst) // RULE8
		else $error("instant reset did not clear timer");

	property p_rx;
		@(posedge mclk) disable iff (rst)
		is_rx |-> eff >= rx_min;
	endproperty
	a_rx: assert property (p_rx) // RULE15
		else $error("logarithmic curve below fixed minimum");

	property p_umin;
		@(posedge mclk) disable iff (rst)
		$rose(trip_q) && limited && umin_q != 32'h0
		|-> $past(ucnt_q) >= umin_q;
	endproperty
	a_umin: assert property (p_umin) // RULE12
		else $error("trip before user minimum");

	property p_clear;
		@(posedge mclk) disable iff (rst)
		clr |=> !trip_q && acc_q == 32'h0 &&
		st_q == gnd_oc_pkg::st_idle;
	endproperty
	a_clear: assert property (p_clear) // RULE17
		else $error("clear-all left element active");

	property p_trip_pu;
		@(posedge mclk) disable iff (rst)
		trip_q |-> pickup_q && $past(acc_q) >= $past(eff);
	endproperty
	a_trip_pu: assert property (p_trip_pu) // RULE18
		else $error("trip without pickup or elapsed delay");

	property p_resume;
		@(posedge mclk) disable iff (rst)
		st_q == gnd_oc_pkg::st_hold && pu && !clr
		|=> st_q == gnd_oc_pkg::st_run && acc_q == $past(acc_q);
	endproperty
	a_resume: assert property (p_resume) // RULE19
		else $error("retained time lost on resume");

endmodule

/* File: dv/gnd_front_model.sv */
/*
 * Ground current front end model: puts the fault magnitude on one of
 * four channels and the forward flag on the matching voltage source.
 * Assumes the bench changes its inputs just after mclk rises.
 */
`timescale 1ns/1ps
module gnd_front_model (
	// stimulus from the bench
	input  wire logic [15:0] amp,
	input  wire logic [1:0]  ch,
	input  wire logic        fwd,
	// ground quantities towards the stage
	output logic      [15:0] meas_fund,
	output logic      [15:0] meas_rms,
	output logic      [15:0] calc_fund,
	output logic      [15:0] calc_rms,
	output logic             dir_fwd_meas,
	output logic             dir_fwd_calc
);
	logic [15:0] low_amp;

	// idle channels carry an eighth, so a wrong source pick still shows
	assign low_amp   = amp >> 3;
	assign meas_fund = (ch == 2'h0) ? amp : low_amp;
	assign meas_rms  = (ch == 2'h1) ? amp : low_amp;
	assign calc_fund = (ch == 2'h2) ? amp : low_amp;
	assign calc_rms  = (ch == 2'h3) ? amp : low_amp;

	// unselected voltage source disagrees on purpose
	assign dir_fwd_meas = ch[1] ? ~fwd : fwd;
	assign dir_fwd_calc = ch[1] ? fwd : ~fwd;
endmodule

/* File: dv/ground_overcurrent_stage_bench.sv */
/*
 * Self-checking bench for the ground overcurrent stage: sources,
 * direction, pickup, curve timing, reset modes, clear and interrupt.
 * Assumes the stage is built with a 10 cycle timing tick.
 */
`timescale 1ns/1ps
module ground_overcurrent_stage_bench;
	localparam int TK = 10;
	logic        mclk, rst, wr, rd, clear_all, fwd, pickup, trip, irq;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, d;
	logic [15:0] amp, lvl, mf, mr, cf, cr;
	logic [1:0]  ch;
	logic        dfm, dfc, dr;
	int          err_count, total_checks, seed, i, k;
	int          t_cv[7] = '{0, 4, 4, 4, 7, 12, 12};
	int          t_cur[7] = '{200, 2000, 4000, 2000, 2000, 2000, 2000};
	int          t_umin[7] = '{0, 0, 0, 300, 0, 0, 300};
	int          t_ms[7] = '{5, 201, 201, 300, 192, 13, 13};

	gnd_front_model front (.amp(amp), .ch(ch), .fwd(fwd),
		.meas_fund(mf), .meas_rms(mr), .calc_fund(cf), .calc_rms(cr),
		.dir_fwd_meas(dfm), .dir_fwd_calc(dfc));

	ground_overcurrent_stage #(.TICK_CYCLES(TK)) DUT (.mclk(mclk),
		.rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .meas_fund(mf), .meas_rms(mr), .calc_fund(cf),
		.calc_rms(cr), .dir_fwd_meas(dfm), .dir_fwd_calc(dfc),
		.clear_all(clear_all), .pickup(pickup), .trip(trip), .irq(irq));

	// clock
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// comparisons
	task automatic check_bit(string nm, logic exp, logic got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s: expected %b seen %b", nm, exp, got);
		end
	endtask
	task automatic check_word(string nm, logic [31:0] exp, logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s: expected %h seen %h", nm, exp, got);
		end
	endtask

	// register port, one gap cycle between accesses
	task automatic wr_reg(logic [7:0] a, logic [31:0] v);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(logic [7:0] a);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic settle();
		repeat (3) @(posedge mclk);
		#1;
	endtask
	task automatic ticks(int n);
		repeat (n * TK) @(posedge mclk);
	endtask

	// control word: enabled, source pair follows the channel index
	function automatic logic [31:0] ctrl_w(int c, int rm, int s, logic dn);
		logic [31:0] w;
		w = 32'h1;
		w[gnd_oc_pkg::F_CURVE +: 4] = 4'(c);
		w[gnd_oc_pkg::F_RMODE +: 2] = 2'(rm);
		w[gnd_oc_pkg::B_RMS] = s[0];
		w[gnd_oc_pkg::B_GCALC] = s[1];
		w[gnd_oc_pkg::B_VCALC] = s[1];
		w[gnd_oc_pkg::B_DIR] = dn;
		return w;
	endfunction

	// trip must stay low until just before ms-1 ticks, then rise soon after
	task automatic wait_trip(int ms);
		repeat ((ms - 1) * TK - 3) @(posedge mclk);
		#1 check_bit("trip early", 1'b0, trip);
		for (int n = 0; n < 3 * TK && trip !== 1'b1; n++)
			@(posedge mclk);
		#1 check_bit("trip", 1'b1, trip);
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// watchdog, well beyond the roughly 17k cycles the tests need
	initial begin
		#5_000_000;
		err_count++;
		finish_test();
	end

	// main sequence
	initial begin
		{rst, wr, rd, clear_all, fwd, addr, wdata, amp, ch} = '0;
		err_count = 0;
		total_checks = 0;
		seed = 61182;
		rst = 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		#1 check_word("outs", 32'h0, {29'h0, pickup, trip, irq});
		rd_reg(gnd_oc_pkg::REG_CTRL);
		check_word("ctrl", 32'h0, d);
		rd_reg(gnd_oc_pkg::REG_TMS);
		check_word("tms", 32'h100, d);
		rd_reg(gnd_oc_pkg::REG_PICKUP);
		check_word("level", 32'hffff, d);
		rd_reg(8'h30);
		check_word("unmapped", 32'h0, d);
		wr_reg(gnd_oc_pkg::REG_STATE, 32'hff);
		rd_reg(gnd_oc_pkg::REG_STATE);
		check_word("state ro", 32'h4, d);

		// every source and method pairing, only the chosen one picks up
		wr_reg(gnd_oc_pkg::REG_PICKUP, 32'd100);
		amp <= 16'd200;
		for (i = 0; i < 4; i++) begin
			ch <= 2'(i);
			for (k = 0; k < 4; k++) begin
				wr_reg(gnd_oc_pkg::REG_CTRL, ctrl_w(0, 0, k, 1'b0));
				settle();
				check_bit("source", i == k, pickup);
			end
		end

		// direction only matters in directional mode
		for (i = 0; i < 8; i++) begin
			ch <= 2'(i);
			fwd <= 1'($random(seed));
			dr = 1'($random(seed));
			wr_reg(gnd_oc_pkg::REG_CTRL, ctrl_w(0, 0, i % 4, dr));
			settle();
			check_bit("direction", !dr || fwd, pickup);
		end

		// random level against random current, first one equal
		ch <= 2'h0;
		wr_reg(gnd_oc_pkg::REG_CTRL, ctrl_w(0, 0, 0, 1'b0));
		for (i = 0; i < 20; i++) begin
			lvl = 16'($random(seed));
			amp <= (i == 0) ? lvl : 16'($random(seed));
			wr_reg(gnd_oc_pkg::REG_PICKUP, {16'h0, lvl});
			settle();
			check_bit("pickup", amp > lvl, pickup);
		end

		// curve timing table, limit is 20x level below 25x nominal
		amp <= 16'h0;
		wr_reg(gnd_oc_pkg::REG_PICKUP, 32'd100);
		wr_reg(gnd_oc_pkg::REG_NOMINAL, 32'd100);
		wr_reg(gnd_oc_pkg::REG_DELAY, 32'd5);
		wr_reg(gnd_oc_pkg::REG_IRQ_EN, 32'h3);
		wr_reg(gnd_oc_pkg::REG_CMD, 32'h1);
		for (i = 0; i < 7; i++) begin
			wr_reg(gnd_oc_pkg::REG_UMIN, 32'(t_umin[i]));
			wr_reg(gnd_oc_pkg::REG_CTRL, ctrl_w(t_cv[i], 0, 0, 1'b0));
			amp <= 16'(t_cur[i]);
			wait_trip(t_ms[i]);
			amp <= 16'h0;
			settle();
			check_bit("dropout", 1'b0, trip);
			if (i == 0) begin
				check_bit("irq", 1'b1, irq);
				rd_reg(gnd_oc_pkg::REG_IRQ_ST);
				check_word("irq status", 32'h3, d);
				wr_reg(gnd_oc_pkg::REG_IRQ_EN, 32'h0);
				settle();
				check_bit("irq masked", 1'b0, irq);
				wr_reg(gnd_oc_pkg::REG_IRQ_ST, 32'h3);
				rd_reg(gnd_oc_pkg::REG_IRQ_ST);
				check_word("irq cleared", 32'h0, d);
			end
			@(posedge mclk);
			clear_all <= 1'b1;
			@(posedge mclk);
			clear_all <= 1'b0;
		end

		// definite reset: time held across a short dip, then resumed
		wr_reg(gnd_oc_pkg::REG_UMIN, 32'h0);
		wr_reg(gnd_oc_pkg::REG_RHOLD, 32'd50);
		wr_reg(gnd_oc_pkg::REG_CTRL, ctrl_w(4, 1, 0, 1'b0));
		amp <= 16'd2000;
		ticks(100);
		amp <= 16'h0;
		ticks(20);
		rd_reg(gnd_oc_pkg::REG_ACC);
		check_bit("acc held", 1'b1, d >= 98 && d <= 101);
		amp <= 16'd2000;
		wait_trip(201 - int'(d));
		amp <= 16'h0;
		ticks(60);
		rd_reg(gnd_oc_pkg::REG_ACC);
		check_word("acc after hold", 32'h0, d);

		// instantaneous, definite_time_curve, log inverse zero; extreme inverse keeps
		for (i = 0; i < 4; i++) begin
			wr_reg(gnd_oc_pkg::REG_CTRL, ctrl_w(i == 1 ? 0 : (i == 3 ? 4 : 9),
				i == 0 ? 0 : (i == 1 ? 1 : 2), 0, 1'b0));
			wr_reg(gnd_oc_pkg::REG_DELAY, 32'd50);
			amp <= 16'd2000;
			ticks(10);
			amp <= 16'h0;
			repeat (3) @(posedge mclk);
			rd_reg(gnd_oc_pkg::REG_ACC);
			check_bit("acc zero", i != 3, d == 32'h0);
		end

		// clear during an inverse reset wipes the retained time
		@(posedge mclk);
		clear_all <= 1'b1;
		@(posedge mclk);
		clear_all <= 1'b0;
		rd_reg(gnd_oc_pkg::REG_ACC);
		check_word("acc cleared", 32'h0, d);
		rd_reg(gnd_oc_pkg::REG_STATE);
		check_word("state cleared", 32'h4, d);

		// sensitive input: limit 2.5x nominal, clamp lands in 10x tier
		wr_reg(gnd_oc_pkg::REG_NOMINAL, 32'd400);
		wr_reg(gnd_oc_pkg::REG_CTRL, ctrl_w(7, 0, 0, 1'b0) |
			(32'h1 << gnd_oc_pkg::B_SENS));
		amp <= 16'd2000;
		wait_trip(407);
		amp <= 16'h0;

		// tiny multiplier pushes the log curve onto its fixed floor
		wr_reg(gnd_oc_pkg::REG_TMS, 32'h1);
		wr_reg(gnd_oc_pkg::REG_CTRL, ctrl_w(9, 0, 0, 1'b0));
		amp <= 16'd2000;
		wait_trip(20);
		amp <= 16'h0;
		finish_test();
	end
endmodule
